//--- rtl/cfra_pkg.sv
// What this block does
// RULE1 - Error flag bit 15, cleared on read
// RULE2 - Success flag bit 14, cleared on read
// RULE3 - Bit 8 picks one of two addresses
// RULE4 - Also accept address with multicast bit set
// RULE5 - Interrupt field: success low, error high
// RULE6 - Interrupt routed through shared status position
// RULE7 - Broadcast PHY address 0x1F accepted by default
// RULE8 - Broadcast reject demands exact own address
// RULE9 - Buffer size field sets transmit delay
// RULE10 - Size zero: no delay, truncate after address
// RULE11 - Enable bit resets from strap, writable
// RULE12 - Bits 13 to 9 read zero
// RULE13 - Event during read keeps its flag
package cfra_pkg;
  // Register address of the configuration register
  localparam logic [4:0] CFG_ADDR = 5'h1F;
  // Field positions
  localparam int ERR_BIT = 15;
  localparam int OK_BIT = 14;
  localparam int DASEL_BIT = 8;
  localparam int IRQ_HI = 7;
  localparam int IRQ_LO = 6;
  localparam int BCREJ_BIT = 5;
  localparam int BUF_HI = 4;
  localparam int BUF_LO = 1;
  localparam int EN_BIT = 0;
  // Writable bit mask, reserved bits 13:9 excluded
  localparam logic [15:0] WR_MASK = 16'h01FF;
  // Reset value of the writable bits, enable from strap
  localparam logic [15:0] CFG_RST = 16'h0000;
  // Broadcast PHY address
  localparam logic [4:0] BCAST_PHY = 5'h1F;
  // Frame byte positions
  localparam logic [4:0] DA_LAST = 5'h05;
  localparam logic [4:0] PHY_BYTE = 5'h0E;
  localparam logic [4:0] REG_BYTE = 5'h0F;
  localparam logic [4:0] DHI_BYTE = 5'h10;
  localparam logic [4:0] DLO_BYTE = 5'h11;
  // Transmit stream beat
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } cfra_beat_t;
  // Register write carried by a frame
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] data;
  } cfra_wr_t;
endpackage : cfra_pkg

//--- rtl/cfra_top.sv
`timescale 1ns/100ps
// Synchronous FIFO with registered ready
module cfra_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  // Depth must be a power of two for pointer wrap
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("cfra_fifo: DEPTH must be a power of two");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr; // Write pointer
  logic [AW-1:0] rptr; // Read pointer
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW:0] next_count = count + AW'(push) - AW'(pop);
  assign out_valid = (count != '0);
  assign out_data = mem[rptr];
  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end
  // Pointers, fill level and ready
  always_ff @(posedge clk) begin
    if (srst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
    end else begin
      wptr <= wptr + AW'(push);
      rptr <= rptr + AW'(pop);
      count <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end
endmodule : cfra_fifo

// Control frame detector, delay buffer and config register
module cfra_top #(
  parameter int DEPTH = 16,
  // Destination addresses: values are arbitrary
  parameter logic [47:0] DEST_ADDR0 = 48'h02_AA_BB_CC_DD_01,
  parameter logic [47:0] DEST_ADDR1 = 48'h02_AA_BB_00_00_00
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic enable_strap,
  input wire logic [4:0] phy_addr,
  input wire logic [4:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  input wire cfra_pkg::cfra_beat_t tx_in,
  output logic tx_out_valid,
  input wire logic tx_out_ready,
  output cfra_pkg::cfra_beat_t tx_out,
  output logic frame_wr_valid,
  output cfra_pkg::cfra_wr_t frame_wr,
  output logic irq_route_sel,
  output logic irq_event
);
  localparam int CW = $clog2(DEPTH) + 1;
  // Buffer size field must fit the FIFO
  initial begin
    if (DEPTH < 16) begin
      $error("cfra_top: DEPTH must be at least 16");
    end
  end
  // Address byte pick for frame position
  function automatic logic [7:0] da_byte(
    input logic [47:0] a, input logic [4:0] i);
    da_byte = a[8'(47 - 8 * int'(i)) -: 8];
  endfunction : da_byte
  logic [15:0] cfg; // Writable configuration bits
  logic err_flag; // Sticky error flag
  logic ok_flag; // Sticky success flag
  logic [4:0] pos; // Byte index within frame
  logic da_ok; // Destination matched so far
  logic in_frame_drop; // Discard rest of truncated frame
  logic [4:0] f_phy; // Captured PHY address field
  logic [4:0] f_reg; // Captured register address
  logic [7:0] f_dhi; // Captured data high byte
  logic [CW-1:0] lasts; // Frame ends held in FIFO
  logic fifo_in_ready;
  logic fifo_out_valid;
  cfra_pkg::cfra_beat_t fifo_out;
  logic [CW-1:0] fifo_count;
  // Field decode
  wire dasel = cfg[cfra_pkg::DASEL_BIT];
  wire [1:0] irq_ctl = cfg[cfra_pkg::IRQ_HI:cfra_pkg::IRQ_LO];
  wire bcrej = cfg[cfra_pkg::BCREJ_BIT];
  wire [3:0] buf_size = cfg[cfra_pkg::BUF_HI:cfra_pkg::BUF_LO];
  wire wr_en = cfg[cfra_pkg::EN_BIT];
  wire bypass = (buf_size == 4'h0);

  // Register access decode
  wire hit = (reg_addr == cfra_pkg::CFG_ADDR);
  wire rd_hit = reg_rd && hit;
  wire wr_hit = reg_wr && hit;

  // Input beat accepted
  wire in_fire = tx_in_valid && tx_in_ready;
  // RULE3 selected address
  wire [47:0] sel_da = dasel ? DEST_ADDR1 : DEST_ADDR0;
  wire [7:0] exp_byte = da_byte(sel_da, pos);
  // RULE4 multicast variant
  wire byte_match = (tx_in.data == exp_byte) ||
    ((pos == 5'h00) && (tx_in.data == (exp_byte | 8'h01)));
  wire in_da = (pos <= cfra_pkg::DA_LAST);
  wire da_now = da_ok && byte_match;
  wire da_done = in_fire && (pos == cfra_pkg::DA_LAST) && da_now;
  wire cf_active = da_ok && !in_da;
  // RULE7 broadcast or own address
  // RULE8 exact match when broadcast rejected
  wire phy_match = (f_phy == phy_addr) ||
    (!bcrej && (f_phy == cfra_pkg::BCAST_PHY));
  // Completion and error events on the input side
  wire done_beat = in_fire && cf_active &&
    (pos == cfra_pkg::DLO_BYTE);
  wire ev_ok = done_beat && phy_match;
  wire ev_err = in_fire && cf_active && tx_in.last &&
    (pos < cfra_pkg::DLO_BYTE);

  // RULE10 truncation marks the address end as last
  wire trunc = bypass && da_done;
  wire push_ok = !in_frame_drop;
  cfra_pkg::cfra_beat_t push_beat;
  assign push_beat.data = tx_in.data;
  assign push_beat.last = tx_in.last || trunc;

  // Input stalls on FIFO full, dropped beats included
  assign tx_in_ready = fifo_in_ready;

  // RULE9 hold beats until the buffer fills or a frame ends
  wire release_ok = bypass || (lasts != '0) ||
    (fifo_count > CW'(buf_size));
  wire out_free = !tx_out_valid || tx_out_ready;
  wire pop = fifo_out_valid && release_ok && out_free;
  wire push_last = in_fire && push_ok && push_beat.last;
  wire pop_last = pop && fifo_out.last;

  cfra_fifo #(
    .WIDTH($bits(cfra_pkg::cfra_beat_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(tx_in_valid && push_ok),
    .in_ready(fifo_in_ready),
    .in_data(push_beat),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out),
    .count(fifo_count)
  );

  // Count of frame ends waiting in the FIFO
  always_ff @(posedge clk) begin
    if (srst) begin
      lasts <= '0;
    end else begin
      lasts <= lasts + CW'(push_last) - CW'(pop_last);
    end
  end

  // Output register stage
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_out_valid <= 1'b0;
      tx_out <= '0;
    end else if (out_free) begin
      tx_out_valid <= pop;
      tx_out <= fifo_out;
    end
  end

  // Frame position tracking
  always_ff @(posedge clk) begin
    if (srst) begin
      pos <= '0;
      da_ok <= 1'b1;
      in_frame_drop <= 1'b0;
    end else if (in_fire) begin
      if (tx_in.last) begin
        // Next frame starts fresh
        pos <= '0;
        da_ok <= 1'b1;
        in_frame_drop <= 1'b0;
      end else begin
        pos <= (pos == 5'h1F) ? pos : pos + 5'h01;
        if (in_da) begin
          da_ok <= da_now;
        end
        // RULE10 discard the rest after truncation
        if (trunc) begin
          in_frame_drop <= 1'b1;
        end
      end
    end
  end

  // Capture of the embedded fields
  always_ff @(posedge clk) begin
    if (srst) begin
      f_phy <= '0;
      f_reg <= '0;
      f_dhi <= '0;
    end else if (in_fire && cf_active) begin
      if (pos == cfra_pkg::PHY_BYTE) begin
        f_phy <= tx_in.data[4:0];
      end
      if (pos == cfra_pkg::REG_BYTE) begin
        f_reg <= tx_in.data[4:0];
      end
      if (pos == cfra_pkg::DHI_BYTE) begin
        f_dhi <= tx_in.data;
      end
    end
  end

  // Register write issued by a good frame
  always_ff @(posedge clk) begin
    if (srst) begin
      frame_wr_valid <= 1'b0;
      frame_wr <= '0;
    end else begin
      // RULE11 writes only while enabled
      frame_wr_valid <= ev_ok && wr_en;
      if (ev_ok) begin
        frame_wr.addr <= f_reg;
        frame_wr.data <= {f_dhi, tx_in.data};
      end
    end
  end

  // Configuration bits
  always_ff @(posedge clk) begin
    if (srst) begin
      // RULE11 enable loads from strap
      cfg <= cfra_pkg::CFG_RST;
      cfg[cfra_pkg::EN_BIT] <= enable_strap;
    end else if (wr_hit) begin
      // RULE12 reserved bits never stored
      cfg <= reg_wdata & cfra_pkg::WR_MASK;
    end
  end

  // Sticky flags, set beats clear on read
  always_ff @(posedge clk) begin
    if (srst) begin
      err_flag <= 1'b0;
      ok_flag <= 1'b0;
    end else begin
      // RULE1 error flag
      // RULE13 set wins over read clear
      err_flag <= ev_err || (err_flag && !rd_hit);
      // RULE2 success flag
      ok_flag <= ev_ok || (ok_flag && !rd_hit);
    end
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (rd_hit) begin
      // RULE12 bits 13 to 9 read zero
      reg_rdata <= {err_flag, ok_flag, cfg[13:0] &
        cfra_pkg::WR_MASK[13:0]};
    end
  end

  // Interrupt routing to the shared status register
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_route_sel <= 1'b0;
      irq_event <= 1'b0;
    end else begin
      // RULE6 route when either bit set
      irq_route_sel <= (irq_ctl != 2'b00);
      // RULE5 decode of interrupt control
      irq_event <= (irq_ctl[0] && ev_ok) || (irq_ctl[1] && ev_err);
    end
  end

  // Checks
  property p_err_set;
    @(posedge clk) disable iff (srst) ev_err |=> err_flag;
  endproperty
  a_err_set: assert property (p_err_set) // RULE1
    else $error("error flag not set");
  property p_ok_keep;
    @(posedge clk) disable iff (srst) (rd_hit && ev_ok) |=> ok_flag;
  endproperty
  a_ok_keep: assert property (p_ok_keep) // RULE13
    else $error("success flag lost on read");
  property p_ok_clear;
    @(posedge clk) disable iff (srst)
      (rd_hit && !ev_ok) |=> !ok_flag;
  endproperty
  a_ok_clear: assert property (p_ok_clear) // RULE2
    else $error("success flag not cleared");
  property p_rsvd;
    @(posedge clk) disable iff (srst) reg_rdata[13:9] == 5'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) // RULE12
    else $error("reserved bits nonzero");
  property p_irq;
    @(posedge clk) disable iff (srst)
      irq_event |-> $past(irq_ctl != 2'b00) && irq_route_sel;
  endproperty
  a_irq: assert property (p_irq) // RULE5
    else $error("interrupt while disabled");
  property p_route;
    @(posedge clk) disable iff (srst)
      (irq_ctl == 2'b00) [*2] |-> !irq_route_sel;
  endproperty
  a_route: assert property (p_route) // RULE6
    else $error("routing while disabled");
  property p_wr_en;
    @(posedge clk) disable iff (srst)
      frame_wr_valid |-> $past(wr_en) && ok_flag;
  endproperty
  a_wr_en: assert property (p_wr_en) // RULE11
    else $error("frame write while disabled");
  property p_bcrej;
    @(posedge clk) disable iff (srst)
      (ev_ok && bcrej) |-> (f_phy == phy_addr);
  endproperty
  a_bcrej: assert property (p_bcrej) // RULE8
    else $error("broadcast accepted while rejected");
  property p_trunc;
    @(posedge clk) disable iff (srst)
      (trunc && !tx_in.last) |=> in_frame_drop;
  endproperty
  a_trunc: assert property (p_trunc) // RULE10
    else $error("truncated frame not dropped");
  property p_hold;
    @(posedge clk) disable iff (srst)
      (!bypass && lasts == '0 && fifo_count <= CW'(buf_size))
        |-> !pop;
  endproperty
  a_hold: assert property (p_hold) // RULE9
    else $error("beat released before buffer filled");
  c_ok: cover property (@(posedge clk) disable iff (srst) ev_ok);
  c_err: cover property (@(posedge clk) disable iff (srst) ev_err);
  c_trunc: cover property (@(posedge clk) disable iff (srst) trunc);
  c_full: cover property (@(posedge clk) disable iff (srst)
    !fifo_in_ready);
endmodule : cfra_top

//--- test/cfra_mac_model.sv
`timescale 1ns/100ps
// Packet source standing in for the MAC on the transmit side
module cfra_mac_model (
  input wire logic clk,
  output logic tx_in_valid,
  input wire logic tx_in_ready,
  output cfra_pkg::cfra_beat_t tx_in
);
  logic [7:0] fb [0:31]; // Bytes of the frame last sent
  int sent; // Beats handed to the block, taken or timed out
  int stuck; // Beats that were never taken
  initial begin
    tx_in_valid = 1'b0;
    tx_in = '0;
    sent = 0;
    stuck = 0;
  end
  // Build a frame, then hand it over one held beat at a time
  task automatic send(input logic [47:0] da, input logic [4:0] phy,
      input logic [4:0] ra, input logic [15:0] d, input int len);
    int w;
    for (int i = 0; i < 32; i++) begin
      fb[i] = 8'hA0 + 8'(i);
    end
    {fb[0], fb[1], fb[2], fb[3], fb[4], fb[5]} = da;
    fb[14] = {3'h0, phy};
    fb[15] = {3'h0, ra};
    {fb[16], fb[17]} = d;
    @(posedge clk);
    for (int i = 0; i < len; i++) begin
      #1;
      tx_in_valid = 1'b1;
      tx_in.data = fb[i];
      tx_in.last = (i == len - 1);
      w = 0;
      @(posedge clk);
      // Hold the beat until ready is seen at an edge
      while (tx_in_ready !== 1'b1 && w < 200) begin
        @(posedge clk);
        w++;
      end
      if (w == 200) stuck++;
      sent++;
    end
    #1;
    // Released data does not keep its last value
    tx_in_valid = 1'b0;
    tx_in.data = ~tx_in.data;
  endtask : send
endmodule : cfra_mac_model

//--- test/cfra_top_tb.sv
`timescale 1ns/100ps
// Self-checking bench for the control frame block
module cfra_top_tb;
  localparam logic [47:0] DA0 = 48'h02_11_22_33_44_55; // Arbitrary
  localparam logic [47:0] DA1 = 48'h02_11_22_00_00_00; // Arbitrary
  localparam logic [47:0] MC = 48'h01_00_00_00_00_00; // Multicast bit
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic strap = 1'b1; // Level on the enable strap
  logic [4:0] reg_addr = 5'h00;
  logic reg_rd = 1'b0;
  logic reg_wr = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic tx_in_valid, tx_in_ready, tx_out_valid;
  logic tx_out_ready = 1'b1;
  cfra_pkg::cfra_beat_t tx_in, tx_out;
  logic frame_wr_valid, irq_route_sel, irq_event;
  cfra_pkg::cfra_wr_t frame_wr, wr_v; // Last frame write seen
  logic [7:0] oq [$]; // Bytes seen leaving
  int n_last, wr_n, irq_n, bad_count, samples_checked, w;
  // Clock of 40 ns
  always #20 clk = ~clk;
  cfra_top #(.DEPTH(16), .DEST_ADDR0(DA0), .DEST_ADDR1(DA1)) DUT (
    .clk(clk), .srst(srst), .enable_strap(strap), .phy_addr(5'h03),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_in(tx_in),
    .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
    .tx_out(tx_out), .frame_wr_valid(frame_wr_valid), .frame_wr(frame_wr),
    .irq_route_sel(irq_route_sel), .irq_event(irq_event));
  cfra_mac_model mac (.clk(clk), .tx_in_valid(tx_in_valid),
    .tx_in_ready(tx_in_ready), .tx_in(tx_in));
  // Record output bytes, frame writes and interrupt events
  always @(posedge clk) begin
    if (tx_out_valid === 1'b1 && tx_out_ready) begin
      oq.push_back(tx_out.data);
      n_last += int'(tx_out.last === 1'b1);
    end
    if (frame_wr_valid === 1'b1) begin
      wr_n++;
      wr_v = frame_wr;
    end
    if (irq_event === 1'b1) irq_n++;
  end
  // Compare a count, byte or flag
  task automatic chk_num(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_num
  // Read the config register and compare its value
  task automatic reg_check(input logic [15:0] exp);
    @(posedge clk);
    #1;
    reg_addr = 5'h1F;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    chk_num({16'h0000, reg_rdata}, {16'h0000, exp});
  endtask : reg_check
  // One write strobe
  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask : reg_write
  // Send a frame and let the output settle
  task automatic frame(input logic [47:0] da, input logic [4:0] phy,
      input logic [4:0] ra, input logic [15:0] d, input int len);
    oq.delete();
    mac.send(da, phy, ra, d, len);
    repeat (40) @(posedge clk);
    #1;
  endtask : frame
  // Print counts and verdict, then stop
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1;
    srst = 1'b0;
    reg_check(16'h0001);
    chk_num(irq_route_sel, 0);
    reg_write(5'h1E, 16'hFFFF);
    reg_check(16'h0001);
    reg_write(5'h1F, 16'hFFFF);
    reg_check(16'h01FF);
    chk_num(irq_route_sel, 1);
    // Bypass, success interrupt, broadcast PHY address
    reg_write(5'h1F, 16'h0041);
    frame(DA0, 5'h1F, 5'h04, 16'h1234, 24);
    chk_num(oq.size(), 6);
    chk_num(n_last, 1);
    chk_num(wr_n, 1);
    chk_num(wr_v, {5'h04, 16'h1234});
    chk_num(irq_n, 1);
    reg_check(16'h4041);
    reg_check(16'h0041);
    // Early end is an error, no interrupt for it here
    frame(DA0, 5'h1F, 5'h04, 16'h1234, 12);
    chk_num(irq_n, 1);
    reg_check(16'h8041);
    reg_check(16'h0041);
    // Second address in multicast form, exact PHY match only
    reg_write(5'h1F, 16'h01A1);
    frame(DA1 | MC, 5'h1F, 5'h07, 16'hABCD, 20);
    chk_num(wr_n, 1);
    reg_check(16'h01A1);
    frame(DA1 | MC, 5'h03, 5'h07, 16'hABCD, 20);
    chk_num(wr_v, {5'h07, 16'hABCD});
    chk_num(irq_n, 1);
    reg_check(16'h41A1);
    frame(DA0, 5'h03, 5'h07, 16'hABCD, 20);
    chk_num(wr_n, 2);
    frame(DA1, 5'h03, 5'h07, 16'hABCD, 10);
    chk_num(irq_n, 2);
    reg_check(16'h81A1);
    // Delay buffer of 4, sink stalled until the FIFO refuses
    reg_write(5'h1F, 16'h0008);
    // Routing output follows the stored field one cycle later
    @(posedge clk);
    #1;
    chk_num(irq_route_sel, 0);
    oq.delete();
    tx_out_ready = 1'b0;
    fork
      mac.send(DA0, 5'h1F, 5'h02, 16'h5555, 20);
      begin
        w = 0;
        while (tx_in_ready !== 1'b0 && w < 100) begin
          @(posedge clk);
          w++;
        end
        chk_num(w < 100, 1);
        @(posedge clk);
        #1;
        tx_out_ready = 1'b1;
      end
    join
    repeat (60) @(posedge clk);
    chk_num(oq.size(), 20);
    foreach (oq[i]) chk_num(oq[i], mac.fb[i]);
    chk_num(wr_n, 2);
    reg_check(16'h4008);
    chk_num(mac.stuck, 0);
    // Second reset with the strap low, enable stays writable
    strap = 1'b0;
    srst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    reg_check(16'h0000);
    chk_num(irq_route_sel, 0);
    reg_write(5'h1F, 16'h0001);
    reg_check(16'h0001);
    // Read strobe lands on the edge that completes a frame
    fork
      mac.send(DA0, 5'h1F, 5'h09, 16'h0F0F, 20);
      begin
        repeat (17) @(posedge clk);
        reg_check(16'h0001);
      end
    join
    repeat (10) @(posedge clk);
    #1;
    reg_check(16'h4001);
    chk_num(wr_n, 3);
    chk_num(wr_v, {5'h09, 16'h0F0F});
    chk_num(mac.stuck, 0);
    print_verdict();
  end
endmodule : cfra_top_tb
